// >>> pkg/ubr_params.svh
`ifndef UBR_PARAMS_SVH
`define UBR_PARAMS_SVH
// =====================================================================
// Register indices (byte address is four times the index)
`define UBR_IDX_RCS 8'h18
`define UBR_IDX_TXS 8'h98
`define UBR_IDX_DIV 8'h99
`define UBR_IDX_RXB 8'h1a
`define UBR_ADDR_W 12
// =====================================================================
// Reset values
`define UBR_RCS_RST 8'h00
`define UBR_TXS_RST 8'h02
`define UBR_DIV_RST 8'h00
// =====================================================================
// Receive control/status fields
`define UBR_RCS_PORT_EN 7
`define UBR_RCS_NINE_BIT 6
`define UBR_RCS_SINGLE 5
`define UBR_RCS_CONT 4
`define UBR_RCS_ADDR_DET 3
`define UBR_RCS_FRAME_ERR 2
`define UBR_RCS_OVERRUN 1
`define UBR_RCS_BIT9 0
// =====================================================================
// Transmit control/status fields
`define UBR_TXS_MASTER 7
`define UBR_TXS_NINE_BIT 6
`define UBR_TXS_TX_EN 5
`define UBR_TXS_SYNC 4
`define UBR_TXS_HIGH_SPD 2
`define UBR_TXS_SHIFT_EMPTY 1
`define UBR_TXS_BIT9 0
`define UBR_TXS_WMASK 8'hf5
// =====================================================================
// Postscaler terminal counts: divide by 64, 16, 4
`define UBR_LAST_LOW 6'd63
`define UBR_LAST_HIGH 6'd15
`define UBR_LAST_SYNC 6'd3
// =====================================================================
// Bus responses
`define UBR_RESP_OKAY 2'b00
`define UBR_RESP_SLVERR 2'b10
`endif

// >>> pkg/ubr_pkg.sv
package ubr_pkg;
  // Bit clock division modes
  typedef enum logic [1:0] {
    UBR_ASYNC_LOW = 2'b00,
    UBR_ASYNC_HIGH = 2'b01,
    UBR_SYNC_MASTER = 2'b11,
    UBR_SYNC_SLAVE = 2'b10
  } ubr_mode_t;
  // Write channel state, one bit changes per step via ADDR or DATA; IDLE to RESP and RESP to IDLE change two
  typedef enum logic [1:0] {
    UBR_W_IDLE = 2'b00,
    UBR_W_ADDR = 2'b01,
    UBR_W_RESP = 2'b11,
    UBR_W_DATA = 2'b10
  } ubr_wstate_t;
endpackage : ubr_pkg

// >>> hdl/ubr_vote.sv
`timescale 1ns/1ps
`default_nettype none
`include "ubr_params.svh"
module ubr_vote (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_i,
  input wire logic sample_i,
  output logic bit_o
);
  logic [2:0] smp_ff;

  // =====================================================================
  // Three samples per bit, two of three decide
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smp_ff <= 3'h7;
    end else if (sample_i) begin
      smp_ff <= {smp_ff[1:0], rx_i};
    end
  end

  // Majority of the three samples
  assign bit_o = (smp_ff[0] & smp_ff[1]) | (smp_ff[1] & smp_ff[2]) |
                 (smp_ff[0] & smp_ff[2]);
endmodule : ubr_vote
`default_nettype wire

// >>> hdl/ubr_baud.sv
`timescale 1ns/1ps
`default_nettype none
`include "ubr_params.svh"
module ubr_baud
  import ubr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] div_i,
  input wire logic div_wr_i,
  input wire ubr_pkg::ubr_mode_t mode_i,
  input wire logic ext_edge_i,
  output logic tick_o,
  output logic sample_o,
  output logic clk_level_o
);
  logic [7:0] cnt_ff;
  logic [5:0] post_ff;
  logic [5:0] last;
  logic [5:0] mid;
  logic pre;

  // =====================================================================
  // Terminal count picks the divide ratio per mode
  always_comb begin
    case (mode_i)
      UBR_ASYNC_LOW: last = `UBR_LAST_LOW;
      UBR_ASYNC_HIGH: last = `UBR_LAST_HIGH;
      default: last = `UBR_LAST_SYNC;
    endcase
  end
  assign mid = last >> 1;
  assign pre = (cnt_ff == div_i);

  // Free running 8-bit timer, cleared by a divisor write
  always_ff @(posedge clk_i) begin
    if (rst_i || div_wr_i) begin
      cnt_ff <= 8'h00;
    end else if (pre) begin
      cnt_ff <= 8'h00; // Period of div+1 clocks, any div 0..255
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // Postscaler: 64, 16 or 4 timer periods per bit
  always_ff @(posedge clk_i) begin
    if (rst_i || div_wr_i) begin
      post_ff <= 6'h00;
    end else if (pre) begin
      // Wraps early when a mode change leaves it above the new last
      post_ff <= (post_ff >= last) ? 6'h00 : post_ff + 6'h01;
    end
  end

  // Slave follows the incoming clock, not the formulas
  always_comb begin
    if (mode_i == UBR_SYNC_SLAVE) begin
      tick_o = ext_edge_i;
      sample_o = ext_edge_i;
    end else begin
      tick_o = pre && (post_ff == last);
      sample_o = pre && (post_ff >= mid) && (post_ff <= mid + 6'd2);
    end
  end

  // Master bit clock level: low in the first half of each bit
  assign clk_level_o = (post_ff > mid);
endmodule : ubr_baud
`default_nettype wire

// >>> hdl/ubr_top.sv
// Notes on behaviour
// - One 8-bit baud generator serves both async and sync modes.
// - The timer runs freely with its period set by the divisor.
// - Any divisor from 0 through 255 is valid.
// - In async mode the high-speed select picks 16 or 64.
// - In sync mode the high-speed select is ignored.
// - Async low speed gives clock/(64*(div+1)).
// - Async high speed gives clock/(16*(div+1)).
// - Sync mode gives clock/(4*(div+1)).
// - The formulas hold in async mode and as sync master; a sync slave uses the line clock.
// - Writing the divisor clears the timer at once.
// - Receive data is sampled three times per bit and majority voted; a slave samples once per line clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "ubr_params.svh"
module ubr_top
  import ubr_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [`UBR_ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [`UBR_ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic RECEIVE_DATA_PIN_I,
  input wire logic TRANSMIT_CLOCK_PIN_I,
  output logic TRANSMIT_CLOCK_PIN_O,
  output logic TRANSMIT_CLOCK_PIN_OE_O,
  input wire logic TX_SHIFT_EMPTY_I,
  input wire logic RX_BYTE_DONE_I,
  input wire logic [7:0] RX_BYTE_I,
  input wire logic RX_NINTH_I,
  input wire logic RX_STOP_BIT_I,
  output logic BAUD_TICK_O,
  output logic BIT_STROBE_O,
  output logic RX_BIT_O,
  output logic RX_ACTIVE_O,
  output logic SERIAL_PORT_ENABLE_O
);
  // =====================================================================
  // Register index match against a bus byte address
  function automatic logic reg_hit(input logic [`UBR_ADDR_W-1:0] addr,
                                   input logic [7:0] idx);
    reg_hit = (addr[`UBR_ADDR_W-1:2] == {2'b00, idx});
  endfunction : reg_hit

  ubr_wstate_t wst_ff;
  logic [`UBR_ADDR_W-1:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb0_ff;
  logic [1:0] bresp;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_go;
  logic wr_rcs;
  logic wr_txs;
  logic wr_div;
  logic wr_hit;
  logic rd_go;
  logic rd_buf;

  logic [7:0] div_ff;
  logic [7:0] txs_ff;
  logic port_en_ff;
  logic nine_ff;
  logic single_ff;
  logic cont_ff;
  logic addr_det_ff;
  logic frame_err_ff;
  logic overrun_ff;
  logic bit9_ff;
  logic [7:0] rxbuf_ff;
  logic full_ff;
  logic ext_clk_ff;
  logic rx_bit_ff;

  logic nxt_overrun;
  logic nxt_single;
  logic load_buf;
  logic sync_mode;
  logic master;
  ubr_mode_t mode;
  logic tick;
  logic sample;
  logic clk_level;
  logic voted;
  logic ext_edge;
  logic [7:0] rcs_rd;
  logic [31:0] rd_word;

  // =====================================================================
  // Write channel: address and data in either order, then response
  assign S_AXI_AWREADY_O = (wst_ff == UBR_W_IDLE) || (wst_ff == UBR_W_DATA);
  assign S_AXI_WREADY_O = (wst_ff == UBR_W_IDLE) || (wst_ff == UBR_W_ADDR);
  assign S_AXI_BVALID_O = (wst_ff == UBR_W_RESP);
  assign S_AXI_BRESP_O = bresp;

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      wst_ff <= UBR_W_IDLE;
    end else begin
      case (wst_ff)
        UBR_W_IDLE: begin
          if (S_AXI_AWVALID_I && S_AXI_WVALID_I) begin
            wst_ff <= UBR_W_RESP;
          end else if (S_AXI_AWVALID_I) begin
            wst_ff <= UBR_W_ADDR;
          end else if (S_AXI_WVALID_I) begin
            wst_ff <= UBR_W_DATA;
          end
        end
        UBR_W_ADDR: begin
          if (S_AXI_WVALID_I) begin
            wst_ff <= UBR_W_RESP;
          end
        end
        UBR_W_DATA: begin
          if (S_AXI_AWVALID_I) begin
            wst_ff <= UBR_W_RESP;
          end
        end
        UBR_W_RESP: begin
          if (S_AXI_BREADY_I) begin
            wst_ff <= UBR_W_IDLE;
          end
        end
        default: wst_ff <= UBR_W_IDLE;
      endcase
    end
  end

  // Capture address and data as each is taken
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      awaddr_ff <= '0;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        awaddr_ff <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        wdata_ff <= S_AXI_WDATA_I[7:0];
        wstrb0_ff <= S_AXI_WSTRB_I[0];
      end
    end
  end

  // Commit when the response is taken, at the earliest one cycle after both halves arrived
  assign wr_go = (wst_ff == UBR_W_RESP) && S_AXI_BREADY_I;
  assign wr_hit = reg_hit(awaddr_ff, `UBR_IDX_RCS) ||
                  reg_hit(awaddr_ff, `UBR_IDX_TXS) ||
                  reg_hit(awaddr_ff, `UBR_IDX_DIV) ||
                  reg_hit(awaddr_ff, `UBR_IDX_RXB);
  assign wr_rcs = wr_go && wstrb0_ff && reg_hit(awaddr_ff, `UBR_IDX_RCS);
  assign wr_txs = wr_go && wstrb0_ff && reg_hit(awaddr_ff, `UBR_IDX_TXS);
  assign wr_div = wr_go && wstrb0_ff && reg_hit(awaddr_ff, `UBR_IDX_DIV);

  // Response code is known once the address is held
  always_comb begin
    bresp = wr_hit ? `UBR_RESP_OKAY : `UBR_RESP_SLVERR;
  end

  // =====================================================================
  // Read channel: one read at a time, data one cycle after the address
  assign S_AXI_ARREADY_O = !rvalid_ff;
  assign rd_go = S_AXI_ARVALID_I && !rvalid_ff;
  assign rd_buf = rd_go && reg_hit(S_AXI_ARADDR_I, `UBR_IDX_RXB);
  assign S_AXI_RVALID_O = rvalid_ff;
  assign S_AXI_RDATA_O = rdata_ff;
  assign S_AXI_RRESP_O = rresp_ff;

  assign rcs_rd = {port_en_ff, nine_ff, single_ff, cont_ff, addr_det_ff,
                   frame_err_ff, overrun_ff, bit9_ff};

  // Read multiplexer; the shift-empty status bit shows live device state
  always_comb begin
    rd_word = 32'h0000_0000;
    if (reg_hit(S_AXI_ARADDR_I, `UBR_IDX_RCS)) begin
      rd_word[7:0] = rcs_rd;
    end else if (reg_hit(S_AXI_ARADDR_I, `UBR_IDX_TXS)) begin
      rd_word[7:0] = txs_ff;
      rd_word[`UBR_TXS_SHIFT_EMPTY] = TX_SHIFT_EMPTY_I;
    end else if (reg_hit(S_AXI_ARADDR_I, `UBR_IDX_DIV)) begin
      rd_word[7:0] = div_ff;
    end else if (reg_hit(S_AXI_ARADDR_I, `UBR_IDX_RXB)) begin
      rd_word[7:0] = rxbuf_ff;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `UBR_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= (reg_hit(S_AXI_ARADDR_I, `UBR_IDX_RCS) ||
                   reg_hit(S_AXI_ARADDR_I, `UBR_IDX_TXS) ||
                   reg_hit(S_AXI_ARADDR_I, `UBR_IDX_DIV) ||
                   reg_hit(S_AXI_ARADDR_I, `UBR_IDX_RXB)) ?
                  `UBR_RESP_OKAY : `UBR_RESP_SLVERR;
    end else if (S_AXI_RREADY_I) begin
      rvalid_ff <= 1'b0;
    end
  end

  // =====================================================================
  // Divisor and transmit control registers
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      div_ff <= `UBR_DIV_RST;
    end else if (wr_div) begin
      div_ff <= wdata_ff; // Full 0..255 range
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      txs_ff <= `UBR_TXS_RST;
    end else if (wr_txs) begin
      txs_ff <= (wdata_ff & `UBR_TXS_WMASK) | (txs_ff & ~`UBR_TXS_WMASK);
    end
  end

  // =====================================================================
  // Mode decode: high-speed select only matters when asynchronous
  assign sync_mode = txs_ff[`UBR_TXS_SYNC];
  assign master = txs_ff[`UBR_TXS_MASTER];
  always_comb begin
    if (sync_mode) begin
      mode = master ? UBR_SYNC_MASTER : UBR_SYNC_SLAVE;
    end else if (txs_ff[`UBR_TXS_HIGH_SPD]) begin
      mode = UBR_ASYNC_HIGH;
    end else begin
      mode = UBR_ASYNC_LOW;
    end
  end

  // Incoming line clock edge for slave operation
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      ext_clk_ff <= 1'b0;
    end else begin
      ext_clk_ff <= TRANSMIT_CLOCK_PIN_I;
    end
  end
  assign ext_edge = TRANSMIT_CLOCK_PIN_I && !ext_clk_ff;

  // =====================================================================
  // Shared baud generator, restarted by a divisor write
  ubr_baud i_ubr_baud (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .div_i(div_ff),
    .div_wr_i(wr_div),
    .mode_i(mode),
    .ext_edge_i(ext_edge),
    .tick_o(tick),
    .sample_o(sample),
    .clk_level_o(clk_level)
  );

  // Majority vote over three samples per bit; as slave, over the last three line clock edges
  ubr_vote i_ubr_vote (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .rx_i(RECEIVE_DATA_PIN_I),
    .sample_i(sample),
    .bit_o(voted)
  );

  // Voted bit is held from the end of one bit to the next
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      rx_bit_ff <= 1'b1;
    end else if (tick) begin
      rx_bit_ff <= voted;
    end
  end

  assign BAUD_TICK_O = tick;
  assign BIT_STROBE_O = sample;
  assign RX_BIT_O = rx_bit_ff;

  // Clock pin driven only as a synchronous master with the port on
  assign TRANSMIT_CLOCK_PIN_O = clk_level;
  assign TRANSMIT_CLOCK_PIN_OE_O = port_en_ff && sync_mode && master;

  // =====================================================================
  // Receive control bits; hardware clears single receive
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      port_en_ff <= 1'b0;
      nine_ff <= 1'b0;
      cont_ff <= 1'b0;
      addr_det_ff <= 1'b0;
    end else if (wr_rcs) begin
      port_en_ff <= wdata_ff[`UBR_RCS_PORT_EN];
      nine_ff <= wdata_ff[`UBR_RCS_NINE_BIT];
      cont_ff <= wdata_ff[`UBR_RCS_CONT];
      addr_det_ff <= wdata_ff[`UBR_RCS_ADDR_DET];
    end
  end

  // Self-clear after one byte in sync master, unless continuous is on
  always_comb begin
    nxt_single = single_ff;
    if (RX_BYTE_DONE_I && sync_mode && master && !cont_ff) begin
      nxt_single = 1'b0;
    end else if (wr_rcs) begin
      nxt_single = wdata_ff[`UBR_RCS_SINGLE];
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      single_ff <= 1'b0;
    end else begin
      single_ff <= nxt_single;
    end
  end

  // Continuous overrides single
  assign RX_ACTIVE_O = port_en_ff && (cont_ff || single_ff);
  assign SERIAL_PORT_ENABLE_O = port_en_ff;

  // =====================================================================
  // One-deep receive buffer; a byte into a full buffer is lost unless the buffer is read in that cycle
  assign load_buf = RX_BYTE_DONE_I && (!full_ff || rd_buf);

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      full_ff <= 1'b0;
      rxbuf_ff <= 8'h00;
      bit9_ff <= 1'b0;
      frame_err_ff <= 1'b0;
    end else if (load_buf) begin
      full_ff <= 1'b1;
      rxbuf_ff <= RX_BYTE_I;
      bit9_ff <= RX_NINTH_I;
      frame_err_ff <= !RX_STOP_BIT_I;
    end else if (rd_buf) begin
      full_ff <= 1'b0;
    end
  end

  // Overrun: set wins over the clear by turning continuous off
  always_comb begin
    nxt_overrun = overrun_ff;
    if (wr_rcs && !wdata_ff[`UBR_RCS_CONT]) begin
      nxt_overrun = 1'b0;
    end
    if (RX_BYTE_DONE_I && full_ff && !rd_buf) begin
      nxt_overrun = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      overrun_ff <= 1'b0;
    end else begin
      overrun_ff <= nxt_overrun;
    end
  end
endmodule : ubr_top
`default_nettype wire

// >>> testbench/ubr_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "ubr_params.svh"
// ==========================================
// Port checks for the baud and receive block
module ubr_props (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [`UBR_ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic TRANSMIT_CLOCK_PIN_OE_O,
  input wire logic BAUD_TICK_O,
  input wire logic RX_BIT_O,
  input wire logic RX_ACTIVE_O,
  input wire logic SERIAL_PORT_ENABLE_O
);
  logic [`UBR_ADDR_W-1:0] aw_addr_ff;
  logic mapped;
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);
  // Address of the write under way, for the response code
  always_ff @(posedge CLOCK_I) begin
    if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_addr_ff <= S_AXI_AWADDR_I;
    end
  end
  // Only the four implemented words answer OKAY
  assign mapped = aw_addr_ff inside {12'h060, 12'h068, 12'h260, 12'h264};
  sequence s_b_wait;
    S_AXI_BVALID_O && !S_AXI_BREADY_I;
  endsequence
  sequence s_r_wait;
    S_AXI_RVALID_O && !S_AXI_RREADY_I;
  endsequence
  a_write_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O
    && S_AXI_WVALID_I && S_AXI_WREADY_O |=> S_AXI_BVALID_O)
    else $error("write not answered");
  a_bresp_hold: assert property (s_b_wait |=> S_AXI_BVALID_O
    && $stable(S_AXI_BRESP_O)) else $error("write response dropped");
  a_bresp_map: assert property (S_AXI_BVALID_O |-> S_AXI_BRESP_O ==
    (mapped ? `UBR_RESP_OKAY : `UBR_RESP_SLVERR))
    else $error("wrong write response code");
  a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
    |=> S_AXI_RVALID_O) else $error("read not answered");
  a_ar_refuse: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
    else $error("read address taken while busy");
  a_rdata_byte: assert property (S_AXI_RVALID_O |->
    S_AXI_RDATA_O[31:8] == 24'h0) else $error("upper read bits set");
  a_rdata_hold: assert property (s_r_wait |=> S_AXI_RVALID_O
    && $stable(S_AXI_RDATA_O)) else $error("read data dropped");
  a_oe_port: assert property (
    TRANSMIT_CLOCK_PIN_OE_O |-> SERIAL_PORT_ENABLE_O)
    else $error("clock pin driven with port off");
  a_active_port: assert property (
    RX_ACTIVE_O |-> SERIAL_PORT_ENABLE_O)
    else $error("receive active with port off");
  a_vote_tick: assert property (
    !$stable(RX_BIT_O) |-> $past(BAUD_TICK_O))
    else $error("voted bit moved off a bit boundary");
endmodule : ubr_props
bind ubr_top ubr_props i_ubr_props (.CLOCK_I, .RST_I, .S_AXI_AWADDR_I,
  .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WVALID_I, .S_AXI_WREADY_O,
  .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARVALID_I,
  .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I,
  .TRANSMIT_CLOCK_PIN_OE_O, .BAUD_TICK_O, .RX_BIT_O, .RX_ACTIVE_O,
  .SERIAL_PORT_ENABLE_O);
`default_nettype wire

// >>> testbench/ubr_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// Remote serial node: data line and slave line clock
module ubr_line_model (
  input wire logic clk_i,
  output logic rx_line_o,
  output logic line_clk_o
);
  // Line marks high and the clock stands low between frames
  initial begin
    rx_line_o = 1'b1;
    line_clk_o = 1'b0;
  end
  // One level for len cycles, a single inverted cycle at spike
  task automatic drive_bit(input logic lvl, input int len, input int spike);
    for (int i = 0; i < len; i++) begin
      rx_line_o <= (i == spike) ? ~lvl : lvl;
      @(posedge clk_i);
    end
    rx_line_o <= 1'b1;
  endtask : drive_bit
  // Slow external clock, ten cycles per period
  task automatic clock_edges(input int n);
    repeat (n) begin
      line_clk_o <= 1'b1;
      repeat (5) @(posedge clk_i);
      line_clk_o <= 1'b0;
      repeat (5) @(posedge clk_i);
    end
  endtask : clock_edges
endmodule : ubr_line_model
`default_nettype wire

// >>> testbench/usart_baud_gen_rx_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ubr_params.svh"
module usart_baud_gen_rx_control_bench;
  import ubr_pkg::*;
  typedef struct {logic [7:0] txs; logic [7:0] div; int per;} ubr_row_t;
  localparam logic [11:0] A_RCS = {2'b00, `UBR_IDX_RCS, 2'b00};
  localparam logic [11:0] A_RXB = {2'b00, `UBR_IDX_RXB, 2'b00};
  localparam logic [11:0] A_TXS = {2'b00, `UBR_IDX_TXS, 2'b00};
  localparam logic [11:0] A_DIV = {2'b00, `UBR_IDX_DIV, 2'b00};
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0;
  logic arv = 1'b0, rry = 1'b0, done = 1'b0, ninth = 1'b0, stop = 1'b1;
  logic [11:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rdat;
  logic [3:0] ws = '0;
  logic [7:0] rxb = '0;
  logic [1:0] br, rr;
  logic awr, wr_rdy, bv, arr, rv, rx_pin, ck_pin, ck_o, oe, tick, stb;
  logic rbit, ract, serial_port_enable;
  int err_total = 0, check_count = 0, cycles = 0, ticks = 0, vote_bad = 0;
  int per, nstb, first, nhi;
  logic watch = 1'b0;
  ubr_row_t rows [7] = '{'{8'h00, 8'h00, 64}, '{8'h00, 8'h02, 192},
    '{8'h04, 8'h00, 16}, '{8'h04, 8'hff, 4096}, '{8'h90, 8'h05, 24},
    '{8'h94, 8'h05, 24}, '{8'h90, 8'hff, 1024}};
  ubr_top i_ubr_top (.CLOCK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awa),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_rdy),
    .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rry), .RECEIVE_DATA_PIN_I(rx_pin),
    .TRANSMIT_CLOCK_PIN_I(ck_pin), .TRANSMIT_CLOCK_PIN_O(ck_o),
    .TRANSMIT_CLOCK_PIN_OE_O(oe), .TX_SHIFT_EMPTY_I(1'b1),
    .RX_BYTE_DONE_I(done), .RX_BYTE_I(rxb), .RX_NINTH_I(ninth),
    .RX_STOP_BIT_I(stop), .BAUD_TICK_O(tick), .BIT_STROBE_O(stb),
    .RX_BIT_O(rbit), .RX_ACTIVE_O(ract), .SERIAL_PORT_ENABLE_O(serial_port_enable));
  ubr_line_model i_ubr_line_model (.clk_i(clk), .rx_line_o(rx_pin),
    .line_clk_o(ck_pin));
  // ==================
  // Clock and watchdog
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (tick === 1'b1) ticks++;
    if (watch && rbit !== 1'b1) vote_bad++;
    if (cycles == 80000) begin
      err_total++;
      end_of_test();
    end
  end
  // ============
  // Compare tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t response %b expected %b", $time, got, exp);
    end
  endtask : chk_resp
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  // ==========================================
  // Bus master; waits only on the slave answers
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
      output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    ws <= 4'h1;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awr === 1'b1) begin
        aw_ok = 1'b1;
        awv <= 1'b0;
      end
      if (!w_ok && wr_rdy === 1'b1) begin
        w_ok = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (bv !== 1'b1);
    r = br;
    bry <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    d = rdat;
    r = rr;
    rry <= 1'b0;
  endtask : rd
  task automatic w8(input logic [11:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    @(posedge clk); // Outputs show the new setting from here on
    chk_resp(r, `UBR_RESP_OKAY);
  endtask : w8
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, {24'h0, e});
    chk_resp(r, `UBR_RESP_OKAY);
  endtask : rchk
  // Cycles to the first tick, then one bit period and its strobes
  task automatic measure();
    first = 0;
    do begin
      @(posedge clk);
      first++;
    end while (tick !== 1'b1 && first < 5000);
    per = 0;
    nstb = 0;
    nhi = 0;
    do begin
      @(posedge clk);
      per++;
      if (stb === 1'b1) nstb++;
      if (ck_o === 1'b1) nhi++;
    end while (tick !== 1'b1 && per < 5000);
  endtask : measure
  // Receiver datapath stand-in: one finished byte
  task automatic rx_byte(input logic [7:0] b, input logic s);
    @(posedge clk);
    rxb <= b;
    stop <= s;
    ninth <= 1'b1;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask : rx_byte
  // ==============
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rchk(A_RCS, `UBR_RCS_RST);
    rchk(A_TXS, `UBR_TXS_RST);
    rchk(A_DIV, `UBR_DIV_RST);
    rd(12'h7f0, d, r);
    chk(d, 32'h0);
    chk_resp(r, `UBR_RESP_SLVERR);
    wr(12'h7f0, 8'h55, r);
    chk_resp(r, `UBR_RESP_SLVERR);
    w8(A_RCS, 8'h80);
    chk(32'(serial_port_enable), 32'd1);
    foreach (rows[i]) begin
      w8(A_TXS, rows[i].txs);
      w8(A_DIV, rows[i].div);
      measure();
      chk(32'(per), 32'(rows[i].per));
      chk(32'(nstb), 32'd3);
      chk(32'(oe), 32'(rows[i].txs[7]));
      chk(32'(nhi), 32'(rows[i].per / 2));
    end
    w8(A_TXS, 8'h04);
    w8(A_DIV, 8'hff);
    repeat (1000) @(posedge clk);
    w8(A_DIV, 8'h00);
    measure();
    chk(32'(first <= 17), 32'd1);
    i_ubr_line_model.drive_bit(1'b0, 48, -1);
    chk(32'(rbit), 32'd0);
    i_ubr_line_model.drive_bit(1'b1, 48, -1);
    watch = 1'b1;
    for (int s = 0; s < 16; s++) i_ubr_line_model.drive_bit(1'b1, 16, s);
    watch = 1'b0;
    chk(32'(vote_bad), 32'd0);
    w8(A_TXS, 8'h10);
    chk(32'(oe), 32'd0);
    ticks = 0;
    i_ubr_line_model.clock_edges(4);
    repeat (3) @(posedge clk);
    chk(32'(ticks), 32'd4);
    w8(A_TXS, 8'h00);
    w8(A_RCS, 8'h90);
    rx_byte(8'h5a, 1'b0);
    rchk(A_RCS, 8'h95);
    rchk(A_RXB, 8'h5a);
    rx_byte(8'h3c, 1'b1);
    rchk(A_RCS, 8'h91);
    rx_byte(8'hc3, 1'b1);
    rchk(A_RCS, 8'h93);
    rchk(A_RXB, 8'h3c);
    w8(A_RCS, 8'h90);
    rchk(A_RCS, 8'h93);
    w8(A_RCS, 8'h80);
    rchk(A_RCS, 8'h81);
    w8(A_TXS, 8'h90);
    w8(A_RCS, 8'ha0);
    chk(32'(ract), 32'd1);
    rx_byte(8'h11, 1'b1);
    rchk(A_RCS, 8'h81);
    chk(32'(ract), 32'd0);
    rchk(A_RXB, 8'h11);
    w8(A_RCS, 8'hb0);
    rx_byte(8'h22, 1'b1);
    rchk(A_RCS, 8'hb1);
    chk(32'(ract), 32'd1);
    // Reset in mid-run returns the registers to their reset values
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rchk(A_RCS, `UBR_RCS_RST);
    rchk(A_TXS, `UBR_TXS_RST);
    end_of_test();
  end
endmodule : usart_baud_gen_rx_control_bench
`default_nettype wire
